// *** wdtm_top.v ***
// Contract
// - watchdog count is an 8-bit up-counter advanced by input clock pulses.
// - watchdog mode is active while mode select is 0; software clears it.
// - mode select changes only after two writes; a lone write is ignored.
// - counting starts when count-on=1, guard=0 written while write enable is 1.
// - a pulse at count FF flags overflow and raises the internal reset.
// - internal reset lasts exactly 512 watchdog oscillator cycles.
// - software may write the count; counting continues from that value.
// - preloading gives a period of 256 minus the value, 1 to 256 pulses.
//
// The Wishbone register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "wdtm_map.vh"

module wdtm_top #(
  parameter RST_OSC_CYCLES = `WDTM_RST_OSC_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  // wishbone classic slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // asynchronous pins
  input wire count_clk_i,
  input wire wd_osc_i,
  // internal reset to the system reset logic
  output wire wdt_reset_o
);

  // register state
  reg control1_write_enable;
  reg count_on_bit;
  reg mode_select_bit;
  reg [7:0] wd_count;
  reg ovf_flag;

  // two-write sequence state for the mode bit
  reg mode_armed;
  reg mode_pending;

  // synchronisers and edge detectors
  reg cnt_meta;
  reg cnt_sync;
  reg cnt_prev;
  reg osc_meta;
  reg osc_sync;
  reg osc_prev;

  wire cnt_tick;
  wire osc_tick;
  wire rst_busy;

  // bus decode
  wire bus_req;
  wire wr_hit;
  wire lane0;
  wire wr_ctrl1;
  wire wr_ctrl2;
  wire wr_count;
  wire wr_stat;

  // counter control
  wire counting;
  wire overflow;
  reg [31:0] next_rdata;

  // count pin passes two flops before edge detection
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_meta <= 1'b0;
      cnt_sync <= 1'b0;
      cnt_prev <= 1'b0;
    end
    else
    begin
      cnt_meta <= count_clk_i;
      cnt_sync <= cnt_meta;
      cnt_prev <= cnt_sync;
    end
  end

  // oscillator pin, same treatment; gives a one-cycle enable per period
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_prev <= 1'b0;
    end
    else
    begin
      osc_meta <= wd_osc_i;
      osc_sync <= osc_meta;
      osc_prev <= osc_sync;
    end
  end

  // rising edges only; pulses faster than half clk_i are lost
  assign cnt_tick = cnt_sync & ~cnt_prev;
  assign osc_tick = osc_sync & ~osc_prev;

  // a request is taken at the edge where ack is already high
  assign bus_req = wb_cyc_i & wb_stb_i;
  assign wr_hit = bus_req & wb_we_i & wb_ack_o;
  assign lane0 = wb_sel_i[0];
  assign wr_ctrl1 = wr_hit & lane0 & (wb_adr_i == `WDTM_OFS_CTRL1);
  assign wr_ctrl2 = wr_hit & lane0 & (wb_adr_i == `WDTM_OFS_CTRL2);
  assign wr_count = wr_hit & lane0 & (wb_adr_i == `WDTM_OFS_COUNT);
  assign wr_stat = wr_hit & lane0 & (wb_adr_i == `WDTM_OFS_STAT);

  // counting needs watchdog mode and count-on
  assign counting = count_on_bit & ~mode_select_bit;
  assign overflow = counting & cnt_tick & (wd_count == `WDTM_COUNT_MAX);

  // wishbone ack: one cycle high, then low for at least one cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else
    begin
      wb_ack_o <= bus_req & ~wb_ack_o;
    end
  end

  // read mux; unmapped offsets read as zero
  always @*
  begin
    next_rdata = 32'h00000000;
    if (wb_adr_i == `WDTM_OFS_CTRL1)
    begin
      next_rdata[`WDTM_C1_WE_BIT] = control1_write_enable;
      next_rdata[`WDTM_C1_ON_BIT] = count_on_bit;
      next_rdata[`WDTM_C1_GUARD_BIT] = 1'b1; // guard always reads 1
    end
    else if (wb_adr_i == `WDTM_OFS_CTRL2)
    begin
      next_rdata[`WDTM_C2_MODE_BIT] = mode_select_bit;
    end
    else if (wb_adr_i == `WDTM_OFS_COUNT)
    begin
      next_rdata[7:0] = wd_count;
    end
    else if (wb_adr_i == `WDTM_OFS_STAT)
    begin
      next_rdata[`WDTM_ST_OVF_BIT] = ovf_flag;
      next_rdata[`WDTM_ST_RST_BIT] = rst_busy;
    end
  end

  // read data is captured with the ack so it stands while ack is high
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h00000000;
    end
    else if (bus_req & ~wb_ack_o & ~wb_we_i)
    begin
      wb_dat_o <= next_rdata;
    end
  end

  // control 1: write enable is free; count-on is guarded
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control1_write_enable <= `WDTM_RST_WE;
      count_on_bit <= `WDTM_RST_ON;
    end
    else if (wr_ctrl1)
    begin
      control1_write_enable <= wb_dat_i[`WDTM_C1_WE_BIT];
      // old write enable is used, so setting both at once sets write enable but leaves count-on unchanged
      if (control1_write_enable && !wb_dat_i[`WDTM_C1_GUARD_BIT])
      begin
        count_on_bit <= wb_dat_i[`WDTM_C1_ON_BIT];
      end
    end
  end

  // mode bit: first write arms with a value, an identical second write
  // to control 2 commits it; a differing one re-arms with its value; a write elsewhere disarms
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_select_bit <= `WDTM_RST_MODE;
      mode_armed <= 1'b0;
      mode_pending <= `WDTM_RST_MODE;
    end
    else if (wr_ctrl2)
    begin
      if (mode_armed && (mode_pending == wb_dat_i[`WDTM_C2_MODE_BIT]))
      begin
        mode_select_bit <= mode_pending;
        mode_armed <= 1'b0;
      end
      else
      begin
        mode_armed <= 1'b1;
        mode_pending <= wb_dat_i[`WDTM_C2_MODE_BIT];
      end
    end
    else if (wr_hit)
    begin
      mode_armed <= 1'b0;
    end
  end

  // counter: a software write wins over a tick in the same cycle
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wd_count <= `WDTM_RST_COUNT;
    end
    else if (wr_count)
    begin
      wd_count <= wb_dat_i[7:0];
    end
    else if (counting && cnt_tick)
    begin
      // FF plus one wraps to zero, so a preload v overflows after 256-v
      wd_count <= wd_count + 8'h01;
    end
  end

  // overflow flag: sticky, write 1 clears, a new overflow wins
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ovf_flag <= 1'b0;
    end
    else if (overflow)
    begin
      ovf_flag <= 1'b1;
    end
    else if (wr_stat && wb_dat_i[`WDTM_ST_OVF_BIT])
    begin
      ovf_flag <= 1'b0;
    end
  end

  // reset stretcher counts oscillator enables, not clk_i cycles
  wdtm_rst_gen #(
    .OSC_CYCLES(RST_OSC_CYCLES),
    .CW(10)
  ) u_rst_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .osc_tick_i(osc_tick),
    .start_i(overflow),
    .busy_o(rst_busy)
  );

  // flop output of the stretcher drives the pin directly
  assign wdt_reset_o = rst_busy;

endmodule // wdtm_top

`default_nettype wire

// *** wdtm_map.vh ***
`ifndef WDTM_MAP_VH
`define WDTM_MAP_VH

// register byte offsets on the wishbone bus
`define WDTM_OFS_CTRL1 8'h00
`define WDTM_OFS_CTRL2 8'h04
`define WDTM_OFS_COUNT 8'h08
`define WDTM_OFS_STAT 8'h0C

// control 1 fields
`define WDTM_C1_WE_BIT 0
`define WDTM_C1_ON_BIT 1
`define WDTM_C1_GUARD_BIT 2

// control 2 fields
`define WDTM_C2_MODE_BIT 0

// status fields
`define WDTM_ST_OVF_BIT 0
`define WDTM_ST_RST_BIT 1

// reset values
`define WDTM_RST_WE 1'b0
`define WDTM_RST_ON 1'b0
`define WDTM_RST_MODE 1'b1
`define WDTM_RST_COUNT 8'h00

// counter limits and reset length in oscillator cycles
`define WDTM_COUNT_MAX 8'hFF
`define WDTM_RST_OSC_CYCLES 512

`endif

// *** wdtm_rst_gen.v ***
`timescale 1ns/10ps
`default_nettype none
`include "wdtm_map.vh"

// stretches an overflow pulse into a reset held for a fixed number of
// watchdog oscillator cycles
module wdtm_rst_gen #(
  parameter OSC_CYCLES = `WDTM_RST_OSC_CYCLES,
  parameter CW = 10
) (
  input wire clk_i,
  input wire rst_i,
  input wire osc_tick_i,
  input wire start_i,
  output reg busy_o
);

  reg [CW-1:0] remain;

  // a new overflow while busy restarts the full length
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      remain <= {CW{1'b0}};
      busy_o <= 1'b0;
    end
    else if (start_i)
    begin
      remain <= OSC_CYCLES[CW-1:0];
      busy_o <= 1'b1;
    end
    else if (busy_o && osc_tick_i)
    begin
      remain <= remain - {{(CW-1){1'b0}}, 1'b1};
      if (remain == {{(CW-1){1'b0}}, 1'b1})
      begin
        busy_o <= 1'b0;
      end
    end
  end

endmodule // wdtm_rst_gen

`default_nettype wire

// *** wdtm_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "wdtm_map.vh"
module wdtm_checker #(
  parameter RST_OSC_CYCLES = 512
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic count_clk_i,
  input wire logic wd_osc_i,
  input wire logic wdt_reset_o
);
  // oscillator period in clk cycles, as the bench makes it
  localparam int OSC_PER = 10;
  int hi_len;
  // cycles the internal reset has stood high so far
  always_ff @(posedge clk_i)
    if (rst_i || !wdt_reset_o)
      hi_len <= 0;
    else
      hi_len <= hi_len + 1;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held too long");
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack late");
  // sync jitter allows up to one oscillator period of slack
  property p_rst_len;
    $fell(wdt_reset_o) |->
      hi_len >= (RST_OSC_CYCLES-1)*OSC_PER && hi_len <= RST_OSC_CYCLES*OSC_PER+6;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset length wrong");
  property p_rst_hold; $rose(wdt_reset_o) |=> wdt_reset_o[*8]; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset too short");
  // the pin must have risen three edges before the reset, through the two-flop sync
  property p_ovf_cause;
    $rose(wdt_reset_o) |-> $past(count_clk_i, 3) && !$past(count_clk_i, 4);
  endproperty
  a_ovf_cause: assert property (p_ovf_cause) else $error("reset without pulse");
  property p_hi_zero; wb_ack_o |-> wb_dat_o[31:8] == 24'h000000; endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("upper data not zero");
  property p_guard;
    wb_ack_o && !wb_we_i && wb_adr_i == `WDTM_OFS_CTRL1 |-> wb_dat_o[`WDTM_C1_GUARD_BIT];
  endproperty
  a_guard: assert property (p_guard) else $error("guard bit not read as one");
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i == 8'h10 |-> wb_dat_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_mode_w;
    wb_ack_o && !wb_we_i && wb_adr_i == `WDTM_OFS_CTRL2 |-> wb_dat_o[31:1] == 31'h0;
  endproperty
  a_mode_w: assert property (p_mode_w) else $error("control 2 extra bits");
  c_write: cover property (wb_ack_o && wb_we_i);
  c_ovf: cover property ($rose(wdt_reset_o));
  c_unm: cover property (wb_ack_o && wb_adr_i == 8'h10);
endmodule // wdtm_checker
bind wdtm_top wdtm_checker #(.RST_OSC_CYCLES(RST_OSC_CYCLES)) u_wdtm_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .count_clk_i(count_clk_i),
  .wd_osc_i(wd_osc_i), .wdt_reset_o(wdt_reset_o));
`default_nettype wire

// *** watchdog_timer_mode_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "wdtm_map.vh"
module watchdog_timer_mode_bench;
  localparam logic [7:0] c1 = `WDTM_OFS_CTRL1, c2 = `WDTM_OFS_CTRL2;
  localparam logic [7:0] cn = `WDTM_OFS_COUNT, st = `WDTM_OFS_STAT;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, cnt_clk = 0, osc = 0;
  logic [7:0] adr = 8'h00, v;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0, e, lfsr = 32'h7EB2E75A;
  logic [31:0] exp_q[$];
  wire logic ack, wdt;
  wire logic [31:0] rdat;
  int miscompares = 0, checks_done = 0, oc = 0;
  always #4 clk_i = ~clk_i;
  wdtm_top #(.RST_OSC_CYCLES(4)) u_wdtm_top (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .count_clk_i(cnt_clk),
    .wd_osc_i(osc), .wdt_reset_o(wdt));
  // oscillator runs free at ten clk cycles a period
  always @(posedge clk_i)
  begin
    oc <= (oc == 4) ? 0 : oc + 1;
    if (oc == 4)
      osc <= ~osc;
  end
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    return {s[30:0], ^(s & 32'h80200003)};
  endfunction
  // one classic cycle; on a read d is the expected word
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    if (!w)
      exp_q.push_back(d);
    do @(posedge clk_i); while (ack !== 1'b1);
    cyc <= 0;
    stb <= 0;
  endtask
  // pin pulse, long enough for the two-flop sync
  task automatic pulse;
    @(posedge clk_i);
    cnt_clk <= 1;
    repeat (4) @(posedge clk_i);
    cnt_clk <= 0;
    repeat (4) @(posedge clk_i);
  endtask
  // direct look at the reset pin between bus cycles
  task automatic chk_pin(input logic x);
    checks_done++;
    if (wdt !== x)
    begin
      miscompares++;
      $display("[ERR] wdt_reset_o exp %b got %b", x, wdt);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // compare each read answer with the oldest note
  always @(posedge clk_i)
    if (ack === 1'b1 && we === 1'b0)
    begin
      e = exp_q.pop_front();
      checks_done++;
      if (rdat !== e)
      begin
        miscompares++;
        $display("[ERR] read %h exp %h got %h", adr, e, rdat);
      end
    end
  initial
  begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    give_verdict;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    bus(0, c2, 32'h1);
    bus(0, c1, 32'h4);
    bus(0, cn, 32'h0);
    bus(1, c2, 32'h0);
    bus(0, c2, 32'h1);
    bus(1, c2, 32'h0);
    bus(0, c2, 32'h0);
    $display("mode test done");
    lfsr = next_rand(lfsr);
    v = lfsr[7:0];
    bus(1, c1, 32'h2);
    bus(0, c1, 32'h4);
    bus(1, cn, {24'h0, v});
    pulse;
    bus(0, cn, {24'h0, v});
    bus(1, c1, 32'h1);
    bus(1, c1, 32'h3);
    bus(0, c1, 32'h7);
    bus(1, c1, 32'h5);
    bus(0, c1, 32'h7);
    $display("start test done");
    repeat (255 - v) pulse;
    bus(0, cn, 32'hFF);
    bus(0, st, 32'h0);
    pulse;
    bus(0, st, 32'h3);
    chk_pin(1'b1);
    bus(0, cn, 32'h0);
    sel <= 4'hE;
    bus(1, cn, 32'h55);
    sel <= 4'hF;
    bus(0, cn, 32'h0);
    bus(1, st, 32'h1);
    repeat (60) @(posedge clk_i);
    bus(0, st, 32'h0);
    chk_pin(1'b0);
    bus(0, 8'h10, 32'h0);
    $display("overflow test done");
    give_verdict;
  end
endmodule // watchdog_timer_mode_bench
`default_nettype wire
